// file: bos_pkg.sv
// package: opcodes, timing and carrier types for the block output sequencer
package bos_pkg;
  localparam logic [7:0] PREFIX_OP = 8'hED;
  localparam logic [7:0] BASE_OP = 8'hA3;
  localparam logic [7:0] OP_MASK = 8'hE7;
  localparam int REPEAT_BIT = 4;
  localparam int DEC_BIT = 3;
  localparam logic [15:0] PC_REWIND = 16'h0002;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [15:0] PTR_ONE = 16'h0001;
  // clock states per machine cycle of one iteration
  localparam logic [2:0] T_M1 = 3'h4;
  localparam logic [2:0] T_M2 = 3'h5;
  localparam logic [2:0] T_M3 = 3'h3;
  localparam logic [2:0] T_M4 = 3'h4;
  localparam logic [2:0] T_M5 = 3'h5;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] dout;
    logic mem_rd;
    logic io_wr;
    logic refresh;
  } bus_req_t;

  typedef struct packed {
    logic zero;
    logic subtract;
  } flag_upd_t;
endpackage

// file: bos_state_timer.sv
// state-count timer: counts clock states inside one machine cycle
`timescale 1ns/1ps
module bos_state_timer (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [2:0] length,
  output logic last
);
  logic [2:0] cnt_q;
  logic run_q;

  assign last = run_q && (cnt_q == 3'h1);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 3'h0;
      run_q <= 1'b0;
    end else if (start) begin
      // start lands one state late; length must be at least two
      cnt_q <= length - 3'h1;
      run_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h1) begin
        run_q <= 1'b0;
      end
    end
  end
endmodule

// file: block_output_sequencer.sv
// block output sequencer: memory-to-port byte transfer instructions
`timescale 1ns/1ps
// How it works
// - read memory at pointer, hold byte
// - decrement count before write; port on low address
// - decremented count drives upper address byte
// - port number picks one of 256 ports
// - held byte driven in I/O write cycle
// - incrementing forms bump pointer after write
// - decrementing step form lowers pointer last
// - repeat with nonzero count rewinds counter by two
// - repeat ends when count reaches zero
// - repeat: interrupt window; four-state refresh only while count is nonzero
// - zero starting count transfers 256 bytes
// - zero flag from count; subtract set
// - repeat iteration 21 states, last 16
// - single step takes 16 states (4,5,3,4)
module block_output_sequencer (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic prefix_valid,
  input wire logic [7:0] prefix_byte,
  input wire logic [7:0] opcode,
  input wire logic [15:0] memory_pointer_pair_in,
  input wire logic [7:0] byte_count_in,
  input wire logic [7:0] port_select,
  input wire logic [15:0] program_counter_in,
  input wire logic [7:0] mem_data,
  output logic busy,
  output logic done,
  output logic int_window,
  output bos_pkg::bus_req_t bus_q,
  output logic [15:0] memory_pointer_pair,
  output logic [7:0] byte_count,
  output logic [15:0] program_counter,
  output bos_pkg::flag_upd_t flags_q,
  output logic flags_valid
);
  typedef enum {IDLE, PREFIX_FETCH, OPCODE_FETCH, MEM_RD, IO_WR,
                REPEAT_TAIL} state_t;
  state_t state_q;
  logic repeat_q, dec_q;
  logic [7:0] hold_q;
  logic start_q;
  logic [2:0] len;
  logic last;
  logic is_block_out;

  function automatic logic [15:0] step_ptr(input logic [15:0] p,
                                           input logic down);
    step_ptr = down ? p - bos_pkg::PTR_ONE : p + bos_pkg::PTR_ONE;
  endfunction

  // repeat forms go round again while the decremented count is nonzero
  function automatic logic more_left(input logic rep,
                                     input logic [7:0] count);
    more_left = rep && (count != 8'h00);
  endfunction

  assign is_block_out = prefix_valid
    && (prefix_byte == bos_pkg::PREFIX_OP)
    && ((opcode & bos_pkg::OP_MASK) == bos_pkg::BASE_OP);

  always_comb begin
    case (state_q)
      PREFIX_FETCH: len = bos_pkg::T_M1;
      OPCODE_FETCH: len = bos_pkg::T_M2;
      MEM_RD: len = bos_pkg::T_M3;
      IO_WR: len = bos_pkg::T_M4;
      REPEAT_TAIL: len = bos_pkg::T_M5;
      default: len = bos_pkg::T_M1;
    endcase
  end

  // one timer run per machine cycle, each no longer than five states
  bos_state_timer u_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(start_q),
    .length(len),
    .last(last)
  );

  assign busy = (state_q != IDLE);

  // sequence: 4+5 fetch, 3 read, 4 write, optional 5 tail
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= IDLE;
      start_q <= 1'b0;
      repeat_q <= 1'b0;
      dec_q <= 1'b0;
      done <= 1'b0;
    end else begin
      start_q <= 1'b0;
      done <= 1'b0;
      case (state_q)
        IDLE: if (is_block_out) begin
          repeat_q <= opcode[bos_pkg::REPEAT_BIT];
          dec_q <= opcode[bos_pkg::DEC_BIT];
          state_q <= PREFIX_FETCH;
          start_q <= 1'b1;
        end
        PREFIX_FETCH: if (last) begin
          state_q <= OPCODE_FETCH;
          start_q <= 1'b1;
        end
        OPCODE_FETCH: if (last) begin
          state_q <= MEM_RD;
          start_q <= 1'b1;
        end
        MEM_RD: if (last) begin
          state_q <= IO_WR;
          start_q <= 1'b1;
        end
        IO_WR: if (last) begin
          if (more_left(repeat_q, byte_count)) begin
            state_q <= REPEAT_TAIL;
            start_q <= 1'b1;
          end else begin
            state_q <= IDLE;
            done <= 1'b1;
          end
        end
        REPEAT_TAIL: if (last) begin
          state_q <= IDLE;
          done <= 1'b1;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // pointer: loaded at start, stepped once the port write is over
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      memory_pointer_pair <= 16'h0000;
    end else if (state_q == IDLE && is_block_out) begin
      memory_pointer_pair <= memory_pointer_pair_in;
    end else if (state_q == IO_WR && last) begin
      memory_pointer_pair <= step_ptr(memory_pointer_pair, dec_q);
    end
  end

  // byte count: 8-bit wrap makes a zero start give 256 transfers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      byte_count <= 8'h00;
    end else if (state_q == IDLE && is_block_out) begin
      byte_count <= byte_count_in;
    end else if (state_q == MEM_RD && last) begin
      byte_count <= byte_count - bos_pkg::COUNT_ONE;
    end
  end

  // program counter: rewound so the same instruction runs again
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      program_counter <= 16'h0000;
    end else if (state_q == IDLE && is_block_out) begin
      program_counter <= program_counter_in;
    end else if (state_q == IO_WR && last
                 && more_left(repeat_q, byte_count)) begin
      program_counter <= program_counter - bos_pkg::PC_REWIND;
    end
  end

  // memory byte, held until the port write has used it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 8'h00;
    end else if (state_q == MEM_RD && last) begin
      hold_q <= mem_data;
    end
  end

  // bus cycles seen by memory and the peripheral
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_q <= '0;
    end else begin
      bus_q.mem_rd <= 1'b0;
      bus_q.io_wr <= 1'b0;
      bus_q.refresh <= 1'b0;
      if (state_q == MEM_RD && !last) begin
        bus_q.addr <= memory_pointer_pair;
        bus_q.mem_rd <= 1'b1;
      end else if (state_q == IO_WR && !last) begin
        bus_q.addr <= {byte_count, port_select};
        bus_q.dout <= hold_q;
        bus_q.io_wr <= 1'b1;
      end else if (state_q == REPEAT_TAIL && !last) begin
        // refresh is held for the last four of the 5 tail states
        bus_q.refresh <= 1'b1;
      end
    end
  end

  // interrupts are sampled once per finished byte transfer of the repeat forms only
  assign int_window = done && repeat_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= '0;
      flags_valid <= 1'b0;
    end else begin
      flags_valid <= 1'b0;
      if (state_q == IO_WR && last) begin
        // repeat forms end only at zero, so zero is set then too
        flags_q.zero <= (byte_count == 8'h00);
        flags_q.subtract <= 1'b1;
        flags_valid <= 1'b1;
      end
    end
  end
endmodule

// file: block_output_sequencer_monitor.sv
// checker: bus and completion properties of the sequencer
`timescale 1ns/1ps
module block_output_sequencer_monitor (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic done,
  input wire logic int_window,
  input wire bos_pkg::bus_req_t bus_q,
  input wire logic [7:0] byte_count,
  input wire bos_pkg::flag_upd_t flags_q,
  input wire logic flags_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_rd_len;
    $rose(bus_q.mem_rd) |-> ##1 bus_q.mem_rd ##1 !bus_q.mem_rd;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read len");
  property p_wr_len;
    $rose(bus_q.io_wr) |-> ##1 bus_q.io_wr[*2] ##1 !bus_q.io_wr;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write len");
  property p_rd_wr;
    $fell(bus_q.mem_rd) |-> ##[1:6] $rose(bus_q.io_wr);
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("no write");
  property p_addr;
    bus_q.io_wr |-> bus_q.addr[15:8] == byte_count;
  endproperty
  a_addr: assert property (p_addr) else $error("upper addr");
  property p_dout;
    bus_q.io_wr && $past(bus_q.io_wr) |-> $stable(bus_q.dout);
  endproperty
  a_dout: assert property (p_dout) else $error("data moved");
  property p_flag;
    flags_valid |-> flags_q.subtract;
  endproperty
  a_flag: assert property (p_flag) else $error("subtract");
  property p_done;
    done |=> !done;
  endproperty
  a_done: assert property (p_done) else $error("done len");
  property p_int;
    int_window |-> done;
  endproperty
  a_int: assert property (p_int) else $error("int window");
  property p_refresh;
    $rose(bus_q.refresh) |-> bus_q.refresh[*4] ##1 !bus_q.refresh;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh");
  property p_sflag;
    done && !int_window |-> flags_valid;
  endproperty
  a_sflag: assert property (p_sflag) else $error("no flags");
endmodule
bind block_output_sequencer block_output_sequencer_monitor mon (.sys_clk,
  .resetn, .done, .int_window, .bus_q, .byte_count, .flags_q, .flags_valid);

// file: bos_periph_model.sv
// partner model: memory bytes and one I/O-mapped peripheral
`timescale 1ns/1ps
module bos_periph_model #(parameter logic [7:0] PORT_ID = 8'h07) (
  input wire logic sys_clk,
  input wire bos_pkg::bus_req_t bus_q,
  output logic [7:0] mem_data,
  output logic [7:0] got_byte,
  output logic [15:0] got_addr
);
  logic [7:0] idle_q = 8'hA5;
  logic wr_q = 1'b0;
  // released bus toggles so a late sample cannot pass by luck
  always @(posedge sys_clk) idle_q <= ~idle_q;
  assign mem_data = bus_q.mem_rd ?
    (bus_q.addr[7:0] ^ bus_q.addr[15:8] ^ 8'h5A) : idle_q;
  always @(posedge sys_clk) begin
    wr_q <= bus_q.io_wr;
    if (bus_q.io_wr && !wr_q && bus_q.addr[7:0] == PORT_ID) begin
      got_addr <= bus_q.addr;
      got_byte <= bus_q.dout;
    end
  end
endmodule

// file: tb.sv
// testbench: issues instructions, judges bus traffic and results
`timescale 1ns/1ps
module tb;
  logic sys_clk = 0, resetn = 0, pv = 0, busy, done, iw, fv;
  logic [7:0] pb = 8'hED, op = 8'h00, cnt = 8'h00, md, gb, cnt_o;
  logic [15:0] ptr = 16'h0000, ga, ptr_o, pc_o;
  logic [7:0] port = 8'h07;
  bos_pkg::bus_req_t bus_q;
  bos_pkg::flag_upd_t fl;
  int n_mismatch = 0, compares = 0, lat;
  always #25 sys_clk = ~sys_clk;
  block_output_sequencer DUT (.sys_clk, .resetn, .prefix_valid(pv),
    .prefix_byte(pb), .opcode(op), .memory_pointer_pair_in(ptr),
    .byte_count_in(cnt), .port_select(port), .program_counter_in(16'h0100),
    .mem_data(md), .busy, .done, .int_window(iw), .bus_q,
    .memory_pointer_pair(ptr_o), .byte_count(cnt_o),
    .program_counter(pc_o), .flags_q(fl), .flags_valid(fv));
  bos_periph_model peer (.sys_clk, .bus_q, .mem_data(md), .got_byte(gb),
    .got_addr(ga));
  function automatic logic [7:0] f(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic go(input logic [7:0] o, input logic [15:0] p,
                    input logic [7:0] c);
    @(negedge sys_clk);
    op = o; ptr = p; cnt = c; pv = 1;
    @(posedge sys_clk);
    lat = 0;
    @(negedge sys_clk);
    pv = 0;
    while (done !== 1'b1 && lat < 40) begin
      @(posedge sys_clk);
      #1 lat++;
    end
  endtask
  task automatic t_step;
    go(8'hA3, 16'h1000, 8'h10);
    cmp(lat, 16, "step time");
    cmp({ptr_o, cnt_o}, 24'h10010F, "ptr cnt");
    cmp({ga, gb}, {16'h0F07, f(16'h1000)}, "write");
    cmp(fl.zero, 0, "zero");
    cmp({iw, fv, busy}, 3'h2, "step end");
    go(8'hAB, 16'h1000, 8'h01);
    cmp({ptr_o, fl.zero}, {16'h0FFF, 1'b1}, "dec");
    @(negedge sys_clk) port = 8'h08;
    go(8'hA3, 16'h1100, 8'h10);
    cmp(lat, 16, "other port time");
    cmp({ga, gb}, {16'h0007, f(16'h1000)}, "other port");
    @(negedge sys_clk) port = 8'h07;
    $display("step test ended");
  endtask
  task automatic t_rep(input logic [7:0] o, input logic [7:0] c, int n);
    int k;
    logic [15:0] p;
    logic [7:0] e;
    k = 0;
    p = 16'h2000;
    do begin
      go(o, p, c);
      k++;
      e = c - 8'h01;
      cmp(gb, f(p), "byte");
      cmp(ga, {e, 8'h07}, "port addr");
      cmp(cnt_o, e, "byte count");
      cmp(ptr_o, o[3] ? p - 1 : p + 1, "ptr");
      cmp(lat, e != 0 ? 21 : 16, "time");
      cmp(pc_o, e != 0 ? 16'h00FE : 16'h0100, "pc");
      cmp(iw, 1, "int window");
      p = ptr_o;
      c = e;
    end while (c != 0 && k < 300);
    cmp(fl.zero, 1, "repeat zero");
    cmp(k, n, "count");
    $display("repeat test ended");
  endtask
  task automatic t_refuse;
    go(8'hA2, 16'h3000, 8'h05);
    cmp(lat, 40, "bad op");
    pb = 8'h00;
    go(8'hA3, 16'h3000, 8'h05);
    cmp(lat, 40, "bad prefix");
    $display("refusal test ended");
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #1ms n_mismatch++;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1;
    t_step;
    t_rep(8'hB3, 8'h03, 3);
    t_rep(8'hBB, 8'h00, 256);
    t_refuse;
    stop_test;
  end
endmodule
